// ==== design/i2c_reg_slave.sv ====
`timescale 1ns/100ps
module i2c_reg_slave (
	input  logic       clk,
	input  logic       rst_b,
	input  logic       link_clk,
	i2c_link_if.slave  bus,
	input  logic [1:0] addr_pin_high,
	input  logic [1:0] addr_pin_low,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [3:0] reg_index,
	output logic [1:0] channel_select_bits,
	output logic [7:0] reg_wdata,
	input  logic [7:0] reg_rdata,
	input  logic       reg_rvalid,
	output logic       bus_busy
);

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_RECV = 5'b00010,
		S_ACK  = 5'b00100,
		S_SEND = 5'b01000,
		S_MACK = 5'b10000
	} slave_state_t;

	// ----------------------------------------
	// Link domain reset and input conditioning
	// ----------------------------------------
	logic [1:0]                             rst_pipe;
	logic                                   link_rst_b;
	logic [1:0]                             in_meta;
	logic [1:0]                             in_sync;
	logic [1:0][i2c_port_pkg::FILTER_LEN-1:0] hist;
	logic [1:0]                             filt;
	logic [1:0]                             filt_prev;
	logic [3:0]                             pins_meta;
	logic [3:0]                             pins_sync;

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign link_rst_b = rst_pipe[1];

	// synchronise and filter
	// Index 0 is SCL, index 1 is SDA; both see equal delay, so their order is kept.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_in
			always_ff @(posedge link_clk or negedge link_rst_b) begin
				if (!link_rst_b) begin
					in_meta[gi] <= 1'b1;
					in_sync[gi] <= 1'b1;
					hist[gi]    <= '1;
					filt[gi]    <= 1'b1;
					filt_prev[gi] <= 1'b1;
				end else begin
					in_meta[gi] <= (gi == 0) ? bus.scl : bus.sda;
					in_sync[gi] <= in_meta[gi];
					hist[gi]    <= {hist[gi][i2c_port_pkg::FILTER_LEN-2:0], in_sync[gi]};
					if (&hist[gi])
						filt[gi] <= 1'b1;
					else if (~|hist[gi])
						filt[gi] <= 1'b0;
					filt_prev[gi] <= filt[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			pins_meta <= 4'h0;
			pins_sync <= 4'h0;
		end else begin
			pins_meta <= {addr_pin_high, addr_pin_low};
			pins_sync <= pins_meta;
		end
	end

	// ----------------------------------------
	// Condition and edge decode
	// ----------------------------------------
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic [7:0] own_addr;

	assign scl_rise = filt[0] & ~filt_prev[0];
	assign scl_fall = ~filt[0] & filt_prev[0];
	// START and STOP
	// An SDA edge while SCL stays high is a condition, never data.
	assign start_det = filt[0] & filt_prev[0] & filt_prev[1] & ~filt[1];
	assign stop_det  = filt[0] & filt_prev[0] & ~filt_prev[1] & filt[1];
	assign own_addr  = i2c_port_pkg::dev_address(pins_sync[3:2], pins_sync[1:0]);

	// ----------------------------------------
	// Byte engine
	// ----------------------------------------
	slave_state_t                     state;
	i2c_port_pkg::byte_kind_t         kind;
	logic [3:0]                       bit_cnt;
	logic [7:0]                       shift;
	logic [7:0]                       tx;
	logic [7:0]                       sub;
	logic [7:0]                       wr_data;
	logic [7:0]                       rd_word;
	logic                             rd_dir;
	logic                             sda_low;
	logic                             busy;
	logic                             wr_tgl;
	logic                             rd_tgl;
	logic [2:0]                       rack_sync;
	logic                             addr_hit;
	logic                             ch_ok;
	logic                             accept;
	logic                             byte_end;
	logic [1:0]                       sub_ch;
	logic [7:0]                       rd_hold;
	logic                             rd_ack_tgl;

	assign addr_hit = shift[7:1] == own_addr[7:1];
	assign sub_ch   = sub[i2c_port_pkg::SUB_CH_MSB:i2c_port_pkg::SUB_CH_LSB];
	assign ch_ok    = (sub_ch == i2c_port_pkg::CH_FIRST) || (sub_ch == i2c_port_pkg::CH_SECOND);
	assign accept   = (kind == i2c_port_pkg::K_ADDR) ? addr_hit :
	                  (kind == i2c_port_pkg::K_SUB) ? 1'b1 : ch_ok;
	assign byte_end = scl_fall && (bit_cnt == i2c_port_pkg::ACK_BIT);

	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b)
			rack_sync <= 3'h0;
		else
			rack_sync <= {rack_sync[1:0], rd_ack_tgl};
	end

	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b)
			rd_word <= 8'h00;
		else if (rack_sync[2] ^ rack_sync[1])
			rd_word <= rd_hold;
	end

	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			state   <= S_IDLE;
			kind    <= i2c_port_pkg::K_ADDR;
			bit_cnt <= 4'h0;
			shift   <= 8'h00;
			tx      <= 8'h00;
			sub     <= 8'h00;
			wr_data <= 8'h00;
			rd_dir  <= 1'b0;
			sda_low <= 1'b0;
			busy    <= 1'b0;
			wr_tgl  <= 1'b0;
			rd_tgl  <= 1'b0;
		end else if (start_det) begin
			state   <= S_RECV;
			kind    <= i2c_port_pkg::K_ADDR;
			bit_cnt <= 4'h0;
			sda_low <= 1'b0;
			busy    <= 1'b1;
		end else if (stop_det) begin
			state   <= S_IDLE;
			sda_low <= 1'b0;
			busy    <= 1'b0;
		end else begin
			case (state)
				S_RECV: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], filt[1]};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_end) begin
						bit_cnt <= 4'h0;
						sda_low <= accept;
						state   <= accept ? S_ACK : S_IDLE;
						if (kind == i2c_port_pkg::K_ADDR) begin
							rd_dir <= shift[0];
							if (addr_hit && shift[0])
								rd_tgl <= ~rd_tgl;
						end
						if (kind == i2c_port_pkg::K_SUB)
							sub <= shift;
						if (kind == i2c_port_pkg::K_DATA && ch_ok) begin
							wr_data <= shift;
							wr_tgl  <= ~wr_tgl;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						if (kind == i2c_port_pkg::K_ADDR && rd_dir) begin
							state   <= S_SEND;
							tx      <= rd_word;
							sda_low <= ~rd_word[7];
						end else begin
							state   <= S_RECV;
							sda_low <= 1'b0;
							kind    <= (kind == i2c_port_pkg::K_ADDR) ?
							           i2c_port_pkg::K_SUB : i2c_port_pkg::K_DATA;
						end
					end
				end
				S_SEND: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h7) begin
							bit_cnt <= 4'h0;
							sda_low <= 1'b0;
							state   <= S_MACK;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							tx      <= {tx[6:0], 1'b0};
							sda_low <= ~tx[6];
						end
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						rd_dir <= ~filt[1];
						if (!filt[1])
							rd_tgl <= ~rd_tgl;
					end else if (scl_fall) begin
						state   <= rd_dir ? S_SEND : S_IDLE;
						tx      <= rd_word;
						sda_low <= rd_dir & ~rd_word[7];
					end
				end
				S_IDLE: begin
					sda_low <= 1'b0;
				end
				default: begin
					state   <= S_IDLE;
					sda_low <= 1'b0;
				end
			endcase
		end
	end

	assign bus.s_sda_out = 1'b0;
	assign bus.s_sda_oe  = sda_low;

	// ----------------------------------------
	// User clock domain
	// ----------------------------------------
	// Data and subaddress are held in the link domain for a whole byte time after each
	// toggle, so the user side may read them once the toggle has passed two flops.
	logic [2:0] wr_sync;
	logic [2:0] rd_sync;
	logic [1:0] busy_sync;
	logic       wr_evt;
	logic       rd_evt;

	assign wr_evt = wr_sync[2] ^ wr_sync[1];
	assign rd_evt = rd_sync[2] ^ rd_sync[1];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_sync   <= 3'h0;
			rd_sync   <= 3'h0;
			busy_sync <= 2'h0;
		end else begin
			wr_sync   <= {wr_sync[1:0], wr_tgl};
			rd_sync   <= {rd_sync[1:0], rd_tgl};
			busy_sync <= {busy_sync[0], busy};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_wr              <= 1'b0;
			reg_rd              <= 1'b0;
			reg_index           <= 4'h0;
			channel_select_bits <= 2'h0;
			reg_wdata           <= 8'h00;
			rd_hold             <= 8'h00;
			rd_ack_tgl          <= 1'b0;
		end else begin
			reg_wr <= wr_evt;
			reg_rd <= rd_evt;
			if (wr_evt || rd_evt) begin
				reg_index           <= sub[i2c_port_pkg::SUB_REG_MSB:i2c_port_pkg::SUB_REG_LSB];
				channel_select_bits <= sub_ch;
			end
			if (wr_evt)
				reg_wdata <= wr_data;
			if (reg_rvalid) begin
				rd_hold    <= reg_rdata;
				rd_ack_tgl <= ~rd_ack_tgl;
			end
		end
	end

	assign bus_busy = busy_sync[1];

endmodule

// ==== design/i2c_port_pkg.sv ====
package i2c_port_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned SCL_HZ         = 100_000;
	localparam int unsigned QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
	localparam int unsigned FILTER_LEN     = 3;
	localparam logic [3:0]  ACK_BIT        = 4'h8;

	// ----------------------------------------
	// Addressing
	// ----------------------------------------
	localparam logic [7:0] ADDR_BASE  = 8'h90;
	localparam logic [1:0] PIN_VDD    = 2'h0;
	localparam logic [1:0] PIN_VSS    = 2'h1;
	localparam logic [1:0] PIN_SCL    = 2'h2;
	localparam logic [1:0] PIN_SDA    = 2'h3;
	localparam int unsigned SUB_REG_MSB = 6;
	localparam int unsigned SUB_REG_LSB = 3;
	localparam int unsigned SUB_CH_MSB  = 2;
	localparam int unsigned SUB_CH_LSB  = 1;
	localparam logic [1:0] CH_FIRST   = 2'h0;
	localparam logic [1:0] CH_SECOND  = 2'h1;

	typedef enum logic [3:0] {
		OP_START = 4'b0001,
		OP_STOP  = 4'b0010,
		OP_WRITE = 4'b0100,
		OP_READ  = 4'b1000
	} op_t;

	typedef enum logic [2:0] {
		K_ADDR = 3'b001,
		K_SUB  = 3'b010,
		K_DATA = 3'b100
	} byte_kind_t;

	// Pin codes follow the order VDD, VSS, SCL, SDA for both strap pins.
	function automatic logic [7:0] dev_address(input logic [1:0] high, input logic [1:0] low);
		dev_address = ADDR_BASE + {3'h0, high, 3'h0} + {5'h0, low, 1'b0};
	endfunction

endpackage

// ==== design/i2c_link_if.sv ====
`timescale 1ns/100ps
interface i2c_link_if;
	logic scl;
	logic sda;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic s_sda_out;
	logic s_sda_oe;

	// Open-drain wires: any enabled low driver wins, the pull-up gives high.
	assign scl = ~(m_scl_oe & ~m_scl_out);
	assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

	modport master (
		input  scl,
		input  sda,
		output m_scl_out,
		output m_scl_oe,
		output m_sda_out,
		output m_sda_oe
	);

	modport slave (
		input  scl,
		input  sda,
		output s_sda_out,
		output s_sda_oe
	);
endinterface

// ==== design/i2c_host_master.sv ====
`timescale 1ns/100ps
module i2c_host_master (
	input  logic              clk,
	input  logic              rst_b,
	i2c_link_if.master        bus,
	input  logic              cmd_valid,
	output logic              cmd_ready,
	input  i2c_port_pkg::op_t cmd_op,
	input  logic [7:0]        cmd_data,
	input  logic              cmd_ack,
	output logic              rsp_valid,
	output logic [7:0]        rsp_data,
	output logic              rsp_nack
);

	typedef enum logic [3:0] {
		M_IDLE  = 4'b0001,
		M_START = 4'b0010,
		M_STOP  = 4'b0100,
		M_BYTE  = 4'b1000
	} master_state_t;

	localparam logic [7:0] QUARTER_LAST = 8'(i2c_port_pkg::QUARTER_CYCLES - 1);

	master_state_t state;
	logic [7:0]    q_cnt;
	logic [1:0]    q;
	logic [3:0]    bit_idx;
	logic [7:0]    shift;
	logic          is_read;
	logic          send_ack;
	logic          samp;
	logic          scl_level;
	logic          sda_level;
	logic          next_scl;
	logic          next_sda;
	logic          dbit;
	logic [1:0]    sda_sync;
	logic          tick;
	logic          take;

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	assign tick      = (state != M_IDLE) && (q_cnt == QUARTER_LAST);
	assign cmd_ready = state == M_IDLE;
	assign take      = cmd_valid && cmd_ready;

	// ack a read byte only when cmd_ack was set with its command
	assign dbit = is_read ? ((bit_idx == i2c_port_pkg::ACK_BIT) ? ~send_ack : 1'b1) :
	              ((bit_idx == i2c_port_pkg::ACK_BIT) ? 1'b1 : shift[7]);

	// START and STOP steps are four quarter periods, a byte step nine bits of four each; in a byte step SDA moves only in quarters with SCL low.
	always_comb begin
		next_scl = 1'b1;
		next_sda = 1'b1;
		case (state)
			// START is SDA fall under high SCL
			M_START: begin
				next_scl = (q == 2'h0) ? scl_level : (q != 2'h3);
				next_sda = q[1] ? 1'b0 : 1'b1;
			end
			// STOP is SDA rise under high SCL
			M_STOP: begin
				next_scl = q[1];
				next_sda = (q == 2'h0) ? sda_level : (q == 2'h3);
			end
			M_BYTE: begin
				next_scl = (q == 2'h1) || (q == 2'h2);
				next_sda = dbit;
			end
			M_IDLE: begin
				next_scl = scl_level;
				next_sda = sda_level;
			end
			default: begin
				next_scl = 1'b1;
				next_sda = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			sda_sync <= 2'h3;
		else
			sda_sync <= {sda_sync[0], bus.sda};
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= M_IDLE;
			q_cnt     <= 8'h00;
			q         <= 2'h0;
			bit_idx   <= 4'h0;
			shift     <= 8'h00;
			is_read   <= 1'b0;
			send_ack  <= 1'b0;
			samp      <= 1'b0;
			scl_level <= 1'b1;
			sda_level <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_data  <= 8'h00;
			rsp_nack  <= 1'b0;
		end else begin
			scl_level <= next_scl;
			sda_level <= next_sda;
			rsp_valid <= 1'b0;
			q_cnt     <= (state == M_IDLE || tick) ? 8'h00 : q_cnt + 8'h01;
			if (take) begin
				q        <= 2'h0;
				bit_idx  <= 4'h0;
				shift    <= cmd_data;
				is_read  <= cmd_op == i2c_port_pkg::OP_READ;
				send_ack <= cmd_ack;
				rsp_nack <= 1'b0;
				case (cmd_op)
					i2c_port_pkg::OP_START: state <= M_START;
					i2c_port_pkg::OP_STOP:  state <= M_STOP;
					default:                state <= M_BYTE;
				endcase
			end else if (tick) begin
				q <= q + 2'h1;
				if (q == 2'h2)
					samp <= sda_sync[1];
				if (q == 2'h3) begin
					case (state)
						M_BYTE: begin
							if (bit_idx != i2c_port_pkg::ACK_BIT) begin
								shift   <= {shift[6:0], samp};
								bit_idx <= bit_idx + 4'h1;
							end else begin
								rsp_data <= shift;
								rsp_nack <= samp;
								if (!is_read && samp) begin
									state <= M_STOP;
								end else begin
									state     <= M_IDLE;
									rsp_valid <= 1'b1;
								end
							end
						end
						default: begin
							state     <= M_IDLE;
							rsp_valid <= 1'b1;
						end
					endcase
				end
			end
		end
	end

	assign bus.m_scl_out = 1'b0;
	assign bus.m_scl_oe  = ~scl_level;
	assign bus.m_sda_out = 1'b0;
	assign bus.m_sda_oe  = ~sda_level;

endmodule

// ==== test/i2c_link_props.sv ====
`timescale 1ns/100ps
// --------------------
// Link-level checks
// --------------------
module i2c_link_props (
	input logic       clk,
	input logic       rst_b,
	input logic       link_clk,
	input logic [1:0] addr_pin_high,
	input logic [1:0] addr_pin_low,
	input logic       scl,
	input logic       sda,
	input logic       m_scl_oe,
	input logic       m_sda_oe,
	input logic       s_sda_oe
);
	logic       scl_d;
	logic       sda_d;
	logic       sel;
	logic       rd;
	logic [3:0] cnt;
	logic [2:0] bidx;
	logic [7:0] sh;
	logic [7:0] sub;
	wire  [7:0] own   = 8'h90 + {3'h0, addr_pin_high, 3'h0} + {5'h0, addr_pin_low, 1'b0};
	wire        rise  = scl & ~scl_d;
	wire        cond  = scl & scl_d & (sda ^ sda_d);
	wire        ack_r = rise & (cnt == 4'h8);
	wire        hit   = (bidx == 3'h0) & (cnt == 4'h8) & (sh[7:1] == own[7:1]);
	wire        wr_s  = ack_r & sel & ~rd;

	// Tracking lags the wire by one clk, which is safe because data moves only while SCL is low.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			{sel, rd, cnt, bidx, sh, sub} <= '0;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			if (cond) begin
				cnt  <= 4'h0;
				bidx <= 3'h0;
				sel  <= 1'b0;
			end else if (ack_r) begin
				cnt  <= 4'h0;
				bidx <= (bidx == 3'h7) ? bidx : bidx + 3'h1;
				sel  <= sel | hit;
				rd   <= hit ? sh[0] : rd;
				sub  <= (bidx == 3'h1) ? sh : sub;
			end else if (rise) begin
				cnt <= cnt + 4'h1;
				sh  <= {sh[6:0], sda};
			end
		end
	end

	property ack_is(logic c, logic v);
		@(posedge clk) disable iff (!rst_b) c |-> s_sda_oe == v;
	endproperty

	chk_reset_quiet: assert property (@(posedge clk)
		!rst_b |-> !(s_sda_oe | m_sda_oe | m_scl_oe)) else $error("bus driven during reset");
	chk_slave_low_scl: assert property (@(posedge link_clk) disable iff (!rst_b)
		$changed(s_sda_oe) |-> !scl) else $error("slave moved sda with scl high");
	chk_addr_ack: assert property (ack_is(ack_r && hit, 1'b1))
		else $error("own address not acknowledged");
	chk_silent_unsel: assert property (@(posedge clk) disable iff (!rst_b)
		!(sel || hit) |-> !s_sda_oe) else $error("unselected slave drives sda");
	chk_sub_ack: assert property (ack_is(wr_s && bidx == 3'h1, 1'b1))
		else $error("subaddress not acknowledged");
	chk_data_ack: assert property (ack_is(wr_s && bidx >= 3'h2 && !sub[2], 1'b1))
		else $error("data byte not acknowledged");
	chk_reserved_nack: assert property (ack_is(wr_s && bidx >= 3'h2 && sub[2], 1'b0))
		else $error("reserved channel byte acknowledged");
	chk_read_release: assert property (ack_is(ack_r && sel && rd, 1'b0))
		else $error("transmitting slave holds ack slot");

	cov_write_data: cover property (@(posedge clk) wr_s && bidx >= 3'h2 && s_sda_oe);
	cov_reserved: cover property (@(posedge clk) wr_s && bidx >= 3'h2 && sub[2]);
	cov_read_ack: cover property (@(posedge clk) ack_r && sel && rd && !sda);
endmodule

// ==== test/test_i2c_slave_register_port.sv ====
`timescale 1ns/100ps
// ----------
// Bench
// ----------
module test_i2c_slave_register_port;
	localparam i2c_port_pkg::op_t go   = i2c_port_pkg::OP_START;
	localparam i2c_port_pkg::op_t halt = i2c_port_pkg::OP_STOP;
	localparam i2c_port_pkg::op_t wr   = i2c_port_pkg::OP_WRITE;
	localparam i2c_port_pkg::op_t rd   = i2c_port_pkg::OP_READ;
	logic              clk        = 1'b0;
	logic              link_clk   = 1'b0;
	logic              rst_b      = 1'b1;
	logic              cmd_valid  = 1'b0;
	logic              cmd_ack    = 1'b0;
	logic              reg_rvalid = 1'b0;
	logic [1:0]        pin_h      = 2'h0;
	logic [1:0]        pin_l      = 2'h0;
	logic [7:0]        cmd_data   = 8'h00;
	logic [7:0]        reg_rdata  = 8'h00;
	i2c_port_pkg::op_t cmd_op     = i2c_port_pkg::OP_STOP;
	logic              cmd_ready, rsp_valid, rsp_nack, reg_wr, reg_rd, bus_busy;
	logic [1:0]        ch;
	logic [3:0]        idx;
	logic [7:0]        rsp_data, wdata, own;
	logic [7:0]        wd[4]      = '{8'h00, 8'hFF, 8'h3C, 8'h81};
	logic [7:0]        rs[2]      = '{8'h05, 8'h87};
	logic [13:0]       wq[$];
	int                n_errors   = 0;
	int                total_checks = 0;
	int                cycles     = 0;
	int                n_rd       = 0;
	int                n0;

	i2c_link_if link ();
	i2c_reg_slave i_i2c_reg_slave (.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .bus(link),
		.addr_pin_high(pin_h), .addr_pin_low(pin_l), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_index(idx), .channel_select_bits(ch), .reg_wdata(wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .bus_busy(bus_busy));
	i2c_host_master i_i2c_host_master (.clk(clk), .rst_b(rst_b), .bus(link),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
	i2c_link_props i_i2c_link_props (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
		.addr_pin_high(pin_h), .addr_pin_low(pin_l), .scl(link.scl), .sda(link.sda),
		.m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe));

	initial forever #50 clk = ~clk;
	initial begin
		#3.7;
		forever #6 link_clk = ~link_clk;
	end

	// Register file stand-in: answers a read one cycle later, far inside the allowed bound.
	always @(negedge clk) begin
		if (reg_wr) wq.push_back({ch, idx, wdata});
		reg_rvalid <= reg_rd;
		if (reg_rd) begin
			reg_rdata <= {idx, ch, n_rd[1:0]};
			n_rd++;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic op(input i2c_port_pkg::op_t o, input logic [7:0] d, input logic a,
			input logic nack);
		int n;
		@(negedge clk);
		cmd_op    = o;
		cmd_data  = d;
		cmd_ack   = a;
		cmd_valid = 1'b1;
		for (n = 0; n < 20 && !cmd_ready; n++) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
		for (n = 0; n < 2000 && !rsp_valid; n++) @(negedge clk);
		check({15'h0, rsp_valid}, 16'h0001);
		check({15'h0, rsp_nack}, {15'h0, nack});
		if (o == rd) check({8'h00, rsp_data}, {8'h00, d});
		if (o == go || o == halt) check({15'h0, bus_busy}, {15'h0, o == go});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		// Reset falls after time zero so every asynchronous reset sees a real edge.
		#1 rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		repeat (20) @(negedge clk);
		for (int i = 0; i < 16; i++) begin
			pin_h = i[3:2];
			pin_l = i[1:0];
			own   = 8'(8'h90 + i / 4 * 8 + i % 4 * 2);
			repeat (5) @(negedge clk);
			op(go, 8'h00, 1'b0, 1'b0);
			op(wr, own, 1'b0, 1'b0);
			op(halt, 8'h00, 1'b0, 1'b0);
			if (i % 5 == 0) begin
				op(go, 8'h00, 1'b0, 1'b0);
				op(wr, own ^ 8'h04, 1'b0, 1'b1);
				check({15'h0, bus_busy}, 16'h0000);
			end
		end
		$display("test address straps done");
		op(go, 8'h00, 1'b0, 1'b0);
		op(wr, own, 1'b0, 1'b0);
		op(wr, 8'hDB, 1'b0, 1'b0);
		foreach (wd[k]) op(wr, wd[k], 1'b0, 1'b0);
		op(go, 8'h00, 1'b0, 1'b0);
		op(wr, own, 1'b0, 1'b0);
		op(wr, 8'h20, 1'b0, 1'b0);
		op(wr, 8'h5A, 1'b0, 1'b0);
		op(halt, 8'h00, 1'b0, 1'b0);
		check(16'(wq.size()), 16'h0005);
		foreach (wd[k]) check({2'h0, wq[k]}, {4'h1, 4'hB, wd[k]});
		check({2'h0, wq[4]}, {4'h0, 4'h4, 8'h5A});
		$display("test write done");
		foreach (rs[k]) begin
			op(go, 8'h00, 1'b0, 1'b0);
			op(wr, own, 1'b0, 1'b0);
			op(wr, rs[k], 1'b0, 1'b0);
			op(wr, 8'h77, 1'b0, 1'b1);
		end
		check(16'(wq.size()), 16'h0005);
		$display("test reserved channel done");
		n0 = n_rd;
		op(go, 8'h00, 1'b0, 1'b0);
		op(wr, own, 1'b0, 1'b0);
		op(wr, 8'h4A, 1'b0, 1'b0);
		op(go, 8'h00, 1'b0, 1'b0);
		op(wr, own | 8'h01, 1'b0, 1'b0);
		op(rd, {4'h9, 2'h1, 2'(n0)}, 1'b1, 1'b0);
		op(rd, {4'h9, 2'h1, 2'(n0 + 1)}, 1'b0, 1'b1);
		op(halt, 8'h00, 1'b0, 1'b0);
		check(16'(n_rd - n0), 16'h0002);
		$display("test read done");
		wrap_up();
	end
endmodule
